//--- include/sdp_if.sv
// interface: the digital_io_header pins between the device and the breadboard circuit
`timescale 1ns/100ps
interface sdp_if;
    logic dir_rd;
    logic strobe1_n;
    logic strobe2_n;
    logic [15:0] dev_data_out;
    logic [15:0] dev_data_oe;
    logic [15:0] brd_data_out;
    logic [15:0] brd_data_oe;
    logic [15:0] data_line;

    // wire level: one driver per bit wins, else pulled high
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (dev_data_oe[i]) begin
                data_line[i] = dev_data_out[i];
            end else if (brd_data_oe[i]) begin
                data_line[i] = brd_data_out[i];
            end else begin
                data_line[i] = 1'b1;
            end
        end
    end

    modport device (
        output dir_rd,
        output strobe1_n,
        output strobe2_n,
        output dev_data_out,
        output dev_data_oe,
        input data_line
    );

    modport board (
        input dir_rd,
        input strobe1_n,
        input strobe2_n,
        output brd_data_out,
        output brd_data_oe,
        input data_line
    );
endinterface

//--- include/sdp_pkg.sv
// package: constants and types used by the device end and the testbench of the strobed dual-byte port
package sdp_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int BYTE_PULSE_NS = 3750;
    localparam int WORD_PULSE_NS = 5000;
    localparam int DATA_VALID_NS = 1250;
    // least times round up to whole cycles
    localparam int BYTE_PULSE_CYC = (BYTE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WORD_PULSE_CYC = (WORD_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DATA_VALID_CYC = (DATA_VALID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;

    // ----------------------------------------
    // field layout and reset values
    // ----------------------------------------
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int BIT_IDX_W = 3;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // ----------------------------------------
    // commands
    // ----------------------------------------
    typedef enum logic [2:0] {
        SDP_CMD_WIDTH = 3'h0,
        SDP_CMD_DIR = 3'h1,
        SDP_CMD_WR_BYTE = 3'h2,
        SDP_CMD_WR_WORD = 3'h3,
        SDP_CMD_WR_BIT = 3'h4,
        SDP_CMD_RD_BYTE = 3'h5,
        SDP_CMD_RD_WORD = 3'h6,
        SDP_CMD_RD_BIT = 3'h7
    } sdp_cmd_e;

    // answer status codes
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_BAD_CFG = 2'h1;
    localparam logic [1:0] ST_BAD_ARG = 2'h2;
endpackage

//--- rtl/sdp_board.sv
// board end: breadboard logic answering the strobed dual-byte handshake
`timescale 1ns/100ps
module sdp_board (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // user side
    input wire logic [15:0] user_in_data_in,
    output logic [15:0] user_out_data_out,
    output logic [1:0] user_wr_pulse_out,
    // pins
    sdp_if.board pins
);
    typedef struct packed {
        logic [1:0] strobe_q;
        logic [15:0] drive;
        logic [15:0] oe;
        logic [15:0] captured;
        logic [1:0] wr_pulse;
    } sdp_brd_s;

    sdp_brd_s r;
    sdp_brd_s next_r;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [1:0] low;
        logic [1:0] rise;
        low = ~{pins.strobe2_n, pins.strobe1_n};
        rise = r.strobe_q & ~low;
        next_r = r;
        next_r.strobe_q = low;
        next_r.wr_pulse = 2'b00;
        for (int b = 0; b < 2; b++) begin
            // drive while a read strobe is low; one cycle is well inside the valid delay
            next_r.oe[b*8 +: 8] = {8{low[b] && pins.dir_rd}};
            if (rise[b] && !pins.dir_rd) begin
                next_r.captured[b*8 +: 8] = pins.data_line[b*8 +: 8];
                next_r.wr_pulse[b] = 1'b1;
            end
        end
        next_r.drive = user_in_data_in;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r <= '{strobe_q: 2'b00, drive: 16'h0000, oe: 16'h0000,
                   captured: 16'h0000, wr_pulse: 2'b00};
        end else begin
            r <= next_r;
        end
    end

    assign user_out_data_out = r.captured;
    assign user_wr_pulse_out = r.wr_pulse;
    assign pins.brd_data_out = r.drive;
    assign pins.brd_data_oe = r.oe;
endmodule

//--- rtl/sdp_device.sv
// device end: command sequencer driving the digital_io_port handshake
//
// Notes on behaviour
// - direction line high for read, also idle
// - byte 1 read: 3.75us strobe, sample >=1.25us
// - byte 2 read: same timing on strobe 2
// - word read: both strobes, 5us pulse
// - board drives read data within 1.25us
// - data lines released after any read
// - direction low for write, high after strobes
// - byte 1 write: data valid 1.25us before rise
// - byte 2 write: same on strobe 2
// - word write: both strobes, 16 bits
// - board captures write data on strobe rise
// - written value stays driven until a read of its lanes
// - two channels; grouped word follows channel 001
// - width set before any data access
// - direction set after width; word via 001
// - single-bit access, bit 0 is lsb
// - byte writes 0..255, word writes 16 bits
`timescale 1ns/100ps
module sdp_device #(
    parameter int BYTE_PULSE = sdp_pkg::BYTE_PULSE_CYC,
    parameter int WORD_PULSE = sdp_pkg::WORD_PULSE_CYC,
    parameter int VALID_DLY = sdp_pkg::DATA_VALID_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // command port
    input wire logic cmd_valid_in,
    input wire sdp_pkg::sdp_cmd_e cmd_op_in,
    input wire logic cmd_chan_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic [2:0] cmd_bit_in,
    output logic cmd_ready_out,
    // answer port
    output logic rsp_valid_out,
    output logic [1:0] rsp_status_out,
    output logic [15:0] rsp_data_out,
    // pins
    sdp_if.device pins
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {
        SDP_IDLE = 3'b001,
        SDP_STROBE = 3'b010,
        SDP_DONE = 3'b100
    } sdp_state_e;

    typedef struct packed {
        sdp_state_e state;
        logic [sdp_pkg::CNT_W-1:0] cnt;
        logic is_read;
        logic is_bit;
        logic [2:0] bit_idx;
        logic [1:0] lanes;
        logic word_mode;
        logic [1:0] is_out;
        logic [15:0] out_val;
        logic [15:0] oe;
        logic [15:0] sample;
        logic dir_rd;
        logic s1_n;
        logic s2_n;
        logic ready;
        logic rsp_valid;
        logic [1:0] rsp_status;
        logic [15:0] rsp_data;
    } sdp_dev_s;

    sdp_dev_s r;
    sdp_dev_s next_r;

    function automatic logic [15:0] lane_mask(input logic [1:0] lanes);
        lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [1:0] lanes;
        logic [15:0] val;
        logic out_ok;
        logic [sdp_pkg::CNT_W-1:0] pulse;
        lanes = 2'b00;
        val = 16'h0000;
        out_ok = 1'b0;
        pulse = sdp_pkg::CNT_W'(BYTE_PULSE);
        next_r = r;
        next_r.rsp_valid = 1'b0;
        unique case (r.state)
            SDP_IDLE: begin
                if (cmd_valid_in && r.ready) begin
                    // grouped word: channel 001 holds configuration for both
                    lanes = r.word_mode ? 2'b11 : (cmd_chan_in ? 2'b10 : 2'b01);
                    // byte channels are separate; a grouped word takes channel 001's direction
                    out_ok = r.word_mode ? r.is_out[0] : r.is_out[cmd_chan_in];
                    next_r.rsp_valid = 1'b1;
                    next_r.rsp_status = sdp_pkg::ST_OK;
                    next_r.rsp_data = 16'h0000;
                    next_r.lanes = lanes;
                    next_r.bit_idx = cmd_bit_in;
                    next_r.is_bit = 1'b0;
                    case (cmd_op_in)
                        sdp_pkg::SDP_CMD_WIDTH: begin
                            next_r.word_mode = cmd_data_in[0];
                            if (cmd_data_in[0]) begin
                                next_r.is_out[1] = r.is_out[0];
                            end
                        end
                        sdp_pkg::SDP_CMD_DIR: begin
                            if (r.word_mode) begin
                                next_r.is_out = {2{cmd_data_in[0]}};
                            end else begin
                                next_r.is_out[cmd_chan_in] = cmd_data_in[0];
                            end
                        end
                        sdp_pkg::SDP_CMD_WR_BYTE,
                        sdp_pkg::SDP_CMD_WR_WORD,
                        sdp_pkg::SDP_CMD_WR_BIT: begin
                            if ((cmd_op_in == sdp_pkg::SDP_CMD_WR_WORD) != r.word_mode
                                    && cmd_op_in != sdp_pkg::SDP_CMD_WR_BIT) begin
                                next_r.rsp_status = sdp_pkg::ST_BAD_CFG;
                            end else if (!out_ok) begin
                                next_r.rsp_status = sdp_pkg::ST_BAD_CFG;
                            end else begin
                                val = r.out_val;
                                if (cmd_op_in == sdp_pkg::SDP_CMD_WR_WORD) begin
                                    val = cmd_data_in;
                                end else if (cmd_op_in == sdp_pkg::SDP_CMD_WR_BYTE) begin
                                    if (lanes[1] && !r.word_mode) begin
                                        val[15:8] = cmd_data_in[7:0];
                                    end else begin
                                        val[7:0] = cmd_data_in[7:0];
                                    end
                                end else begin
                                    // bit 0 is lsb of the addressed byte
                                    val[{(lanes[1] && !r.word_mode), cmd_bit_in}]
                                        = cmd_data_in[0];
                                end
                                next_r.rsp_valid = 1'b0;
                                next_r.ready = 1'b0;
                                next_r.is_read = 1'b0;
                                next_r.out_val = val;
                                next_r.oe = r.oe | lane_mask(lanes);
                                next_r.dir_rd = 1'b0;
                                next_r.s1_n = ~lanes[0];
                                next_r.s2_n = ~lanes[1];
                                next_r.cnt = '0;
                                next_r.state = SDP_STROBE;
                            end
                        end
                        default: begin
                            if ((cmd_op_in == sdp_pkg::SDP_CMD_RD_WORD) != r.word_mode
                                    && cmd_op_in != sdp_pkg::SDP_CMD_RD_BIT) begin
                                next_r.rsp_status = sdp_pkg::ST_BAD_CFG;
                            end else begin
                                next_r.rsp_valid = 1'b0;
                                next_r.ready = 1'b0;
                                next_r.is_read = 1'b1;
                                next_r.is_bit = (cmd_op_in == sdp_pkg::SDP_CMD_RD_BIT);
                                next_r.oe = r.oe & ~lane_mask(lanes);
                                next_r.dir_rd = 1'b1;
                                next_r.s1_n = ~lanes[0];
                                next_r.s2_n = ~lanes[1];
                                next_r.cnt = '0;
                                next_r.state = SDP_STROBE;
                            end
                        end
                    endcase
                end
            end
            SDP_STROBE: begin
                pulse = (r.lanes == 2'b11) ? sdp_pkg::CNT_W'(WORD_PULSE)
                                           : sdp_pkg::CNT_W'(BYTE_PULSE);
                next_r.cnt = r.cnt + 1'b1;
                // sample late in the pulse, well past the valid delay
                if (r.is_read && r.cnt == pulse - sdp_pkg::CNT_W'(1)) begin
                    next_r.sample = pins.data_line & lane_mask(r.lanes);
                end
                if (r.cnt == pulse - sdp_pkg::CNT_W'(1)) begin
                    next_r.s1_n = 1'b1;
                    next_r.s2_n = 1'b1;
                    next_r.state = SDP_DONE;
                end
            end
            SDP_DONE: begin
                next_r.dir_rd = 1'b1;
                next_r.ready = 1'b1;
                next_r.rsp_valid = 1'b1;
                next_r.rsp_status = sdp_pkg::ST_OK;
                next_r.rsp_data = 16'h0000;
                if (r.is_read) begin
                    next_r.oe = r.oe & ~lane_mask(r.lanes);
                    if (r.is_bit) begin
                        next_r.rsp_data[0] = r.sample[{r.lanes[1] && !r.word_mode, r.bit_idx}];
                    end else if (r.lanes == 2'b10) begin
                        next_r.rsp_data = {8'h00, r.sample[15:8]};
                    end else begin
                        next_r.rsp_data = r.sample;
                    end
                end
                // writes keep oe and out_val as they are
                next_r.state = SDP_IDLE;
            end
            default: begin
                next_r.state = SDP_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r <= '{state: SDP_IDLE, cnt: '0, is_read: 1'b0, is_bit: 1'b0, bit_idx: 3'h0,
                   lanes: 2'b00, word_mode: 1'b0, is_out: 2'b00,
                   out_val: sdp_pkg::DATA_RESET, oe: 16'h0000, sample: 16'h0000,
                   dir_rd: 1'b1, s1_n: 1'b1, s2_n: 1'b1, ready: 1'b1,
                   rsp_valid: 1'b0, rsp_status: 2'h0, rsp_data: 16'h0000};
        end else begin
            r <= next_r;
        end
    end

    assign cmd_ready_out = r.ready;
    assign rsp_valid_out = r.rsp_valid;
    assign rsp_status_out = r.rsp_status;
    assign rsp_data_out = r.rsp_data;
    assign pins.dir_rd = r.dir_rd;
    assign pins.strobe1_n = r.s1_n;
    assign pins.strobe2_n = r.s2_n;
    assign pins.dev_data_out = r.out_val;
    assign pins.dev_data_oe = r.oe;
endmodule

//--- verif/sdp_assertions.sv
// checker: handshake timing seen on the digital_io_header pins
`timescale 1ns/100ps
module sdp_assertions #(
    parameter int BYTE_PULSE = 150,
    parameter int WORD_PULSE = 200
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // pins
    input wire logic dir_rd,
    input wire logic strobe1_n,
    input wire logic strobe2_n,
    input wire logic [15:0] dev_data_out,
    input wire logic [15:0] dev_data_oe,
    input wire logic [15:0] brd_data_oe
);
    // ----------------------------------------
    // helper: cycles with a strobe low
    // ----------------------------------------
    int low_cnt;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            low_cnt <= 0;
        end else if (!strobe1_n || !strobe2_n) begin
            low_cnt <= low_cnt + 1;
        end else begin
            low_cnt <= 0;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence idle_s;
        strobe1_n && strobe2_n;
    endsequence
    sequence wr1_low_s;
        !strobe1_n && !dir_rd;
    endsequence
    sequence wr2_low_s;
        !strobe2_n && !dir_rd;
    endsequence

    idle_read_a: assert property (idle_s ##1 idle_s |-> dir_rd)
        else $error("direction line low while idle");
    byte_width_a: assert property (($rose(strobe1_n) != $rose(strobe2_n))
        |-> low_cnt == BYTE_PULSE) else $error("byte strobe width wrong");
    word_width_a: assert property ($rose(strobe1_n) && $rose(strobe2_n)
        |-> low_cnt == WORD_PULSE) else $error("word strobe width wrong");
    word_together_a: assert property ($fell(strobe1_n) && !strobe2_n |-> $fell(strobe2_n))
        else $error("word strobes not together");
    write_dir_a: assert property ($fell(dir_rd) |-> !strobe1_n || !strobe2_n)
        else $error("write request without strobe");
    dir_return_a: assert property (!dir_rd && strobe1_n && strobe2_n |=> dir_rd)
        else $error("direction line not raised after write");
    read_release_a: assert property (dir_rd && !strobe1_n ##1 strobe1_n
        |-> dev_data_oe[7:0] == 8'h00) else $error("lanes driven after read");
    wr1_data_a: assert property (wr1_low_s ##1 wr1_low_s
        |-> $stable(dev_data_out[7:0]) && dev_data_oe[7:0] == 8'hff)
        else $error("byte 1 write data not valid");
    wr2_data_a: assert property (wr2_low_s ##1 wr2_low_s
        |-> $stable(dev_data_out[15:8]) && dev_data_oe[15:8] == 8'hff)
        else $error("byte 2 write data not valid");
    hold_after_a: assert property (idle_s ##1 idle_s
        |-> $stable(dev_data_oe) && $stable(dev_data_out)) else $error("lanes changed idle");
    board_answer_a: assert property (dir_rd && !strobe1_n && !$past(strobe1_n)
        |-> brd_data_oe[7:0] == 8'hff) else $error("board late with read data");
endmodule

//--- verif/strobed_dual_byte_dio_port_test.sv
// testbench: device and board ends joined, driven through the command port
`timescale 1ns/100ps
module strobed_dual_byte_dio_port_test;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    sdp_pkg::sdp_cmd_e cmd_op = sdp_pkg::SDP_CMD_WIDTH;
    logic cmd_chan = 1'b0;
    logic [15:0] cmd_data = 16'h0000;
    logic [2:0] cmd_bit = 3'h0;
    logic [15:0] user_in = 16'h0000;
    logic cmd_ready;
    logic rsp_valid;
    logic [1:0] rsp_status;
    logic [15:0] rsp_data;
    logic [15:0] user_out;
    logic [1:0] wr_pulse;
    int fails = 0;
    int n_compared = 0;

    sdp_if sdp_if_i();
    // short pulses keep the run brief
    sdp_device #(.BYTE_PULSE(8), .WORD_PULSE(10), .VALID_DLY(3)) sdp_device_i (
        .core_clk_in(clk), .reset_n_in(reset_n), .cmd_valid_in(cmd_valid),
        .cmd_op_in(cmd_op), .cmd_chan_in(cmd_chan), .cmd_data_in(cmd_data),
        .cmd_bit_in(cmd_bit), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
        .rsp_status_out(rsp_status), .rsp_data_out(rsp_data), .pins(sdp_if_i));
    sdp_board sdp_board_i (
        .core_clk_in(clk), .reset_n_in(reset_n), .user_in_data_in(user_in),
        .user_out_data_out(user_out), .user_wr_pulse_out(wr_pulse), .pins(sdp_if_i));
    sdp_assertions #(.BYTE_PULSE(8), .WORD_PULSE(10)) sdp_assertions_i (
        .core_clk_in(clk), .reset_n_in(reset_n), .dir_rd(sdp_if_i.dir_rd),
        .strobe1_n(sdp_if_i.strobe1_n), .strobe2_n(sdp_if_i.strobe2_n),
        .dev_data_out(sdp_if_i.dev_data_out), .dev_data_oe(sdp_if_i.dev_data_oe),
        .brd_data_oe(sdp_if_i.brd_data_oe));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // holds the command until an edge that samples ready, then waits for the answer
    task automatic cmd(input sdp_pkg::sdp_cmd_e op, input logic ch, input logic [15:0] d,
                       input logic [2:0] b, input logic [1:0] st);
        logic rdy;
        // let an edge pass so valid is never lowered and raised in one time step
        @(posedge clk);
        #1;
        cmd_op = op;
        cmd_chan = ch;
        cmd_data = d;
        cmd_bit = b;
        cmd_valid = 1'b1;
        do begin
            rdy = cmd_ready;
            @(posedge clk);
        end while (rdy !== 1'b1);
        #1;
        cmd_valid = 1'b0;
        chk("ready", {15'h0, !(op > sdp_pkg::SDP_CMD_DIR && st == sdp_pkg::ST_OK)},
            {15'h0, cmd_ready});
        while (rsp_valid !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        chk("status", {14'h0, st}, {14'h0, rsp_status});
    endtask

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic byte_mode;
        cmd(sdp_pkg::SDP_CMD_WIDTH, 1'b0, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        cmd(sdp_pkg::SDP_CMD_WIDTH, 1'b1, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        cmd(sdp_pkg::SDP_CMD_DIR, 1'b0, 16'h0001, 3'h0, sdp_pkg::ST_OK);
        cmd(sdp_pkg::SDP_CMD_DIR, 1'b1, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        cmd(sdp_pkg::SDP_CMD_RD_WORD, 1'b0, 16'h0000, 3'h0, sdp_pkg::ST_BAD_CFG);
        cmd(sdp_pkg::SDP_CMD_WR_BYTE, 1'b0, 16'h009d, 3'h0, sdp_pkg::ST_OK);
        chk("board byte", 16'h009d, {8'h00, user_out[7:0]});
        chk("wr pulse 1", 16'h0001, {14'h0, wr_pulse});
        user_in = 16'ha53c;
        cmd(sdp_pkg::SDP_CMD_RD_BYTE, 1'b1, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        chk("read byte 2", 16'h00a5, {8'h00, rsp_data[7:0]});
        chk("lanes 2 oe", 16'h0000, {8'h00, sdp_if_i.dev_data_oe[15:8]});
        chk("held byte", 16'h009d, {8'h00, sdp_if_i.data_line[7:0]});
        cmd(sdp_pkg::SDP_CMD_WR_BYTE, 1'b1, 16'h0011, 3'h0, sdp_pkg::ST_BAD_CFG);
        cmd(sdp_pkg::SDP_CMD_DIR, 1'b1, 16'h0001, 3'h0, sdp_pkg::ST_OK);
        cmd(sdp_pkg::SDP_CMD_WR_BYTE, 1'b1, 16'h0042, 3'h0, sdp_pkg::ST_OK);
        chk("board byte 2", 16'h0042, {8'h00, user_out[15:8]});
        chk("wr pulse 2", 16'h0002, {14'h0, wr_pulse});
        cmd(sdp_pkg::SDP_CMD_WR_BYTE, 1'b0, 16'h00ff, 3'h0, sdp_pkg::ST_OK);
        chk("board max", 16'h00ff, {8'h00, user_out[7:0]});
    endtask

    task automatic bit_ops;
        cmd(sdp_pkg::SDP_CMD_WR_BIT, 1'b0, 16'h0000, 3'h7, sdp_pkg::ST_OK);
        chk("bit 7", 16'h007f, {8'h00, sdp_if_i.data_line[7:0]});
        cmd(sdp_pkg::SDP_CMD_WR_BIT, 1'b0, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        chk("bit 0", 16'h007e, {8'h00, sdp_if_i.data_line[7:0]});
        cmd(sdp_pkg::SDP_CMD_RD_BIT, 1'b1, 16'h0000, 3'h5, sdp_pkg::ST_OK);
        chk("read bit 5", 16'h0001, {15'h0, rsp_data[0]});
        cmd(sdp_pkg::SDP_CMD_RD_BIT, 1'b1, 16'h0000, 3'h6, sdp_pkg::ST_OK);
        chk("read bit 6", 16'h0000, {15'h0, rsp_data[0]});
        cmd(sdp_pkg::SDP_CMD_DIR, 1'b0, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        cmd(sdp_pkg::SDP_CMD_RD_BYTE, 1'b0, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        chk("read byte 1", 16'h003c, {8'h00, rsp_data[7:0]});
        chk("lanes 1 oe", 16'h0000, {8'h00, sdp_if_i.dev_data_oe[7:0]});
    endtask

    task automatic word_mode;
        cmd(sdp_pkg::SDP_CMD_WIDTH, 1'b0, 16'h0001, 3'h0, sdp_pkg::ST_OK);
        cmd(sdp_pkg::SDP_CMD_DIR, 1'b0, 16'h0001, 3'h0, sdp_pkg::ST_OK);
        cmd(sdp_pkg::SDP_CMD_WR_WORD, 1'b0, 16'h9999, 3'h0, sdp_pkg::ST_OK);
        chk("board word", 16'h9999, user_out);
        chk("wr pulse word", 16'h0003, {14'h0, wr_pulse});
        chk("held word", 16'h9999, sdp_if_i.data_line);
        cmd(sdp_pkg::SDP_CMD_WR_BIT, 1'b0, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        chk("word bit 0", 16'h9998, sdp_if_i.data_line);
        cmd(sdp_pkg::SDP_CMD_WR_BYTE, 1'b0, 16'h0001, 3'h0, sdp_pkg::ST_BAD_CFG);
        cmd(sdp_pkg::SDP_CMD_DIR, 1'b0, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        user_in = 16'h5a3c;
        cmd(sdp_pkg::SDP_CMD_RD_WORD, 1'b0, 16'h0000, 3'h0, sdp_pkg::ST_OK);
        chk("read word", 16'h5a3c, rsp_data);
        chk("word oe", 16'h0000, sdp_if_i.dev_data_oe);
        cmd(sdp_pkg::SDP_CMD_RD_BIT, 1'b0, 16'h0000, 3'h2, sdp_pkg::ST_OK);
        chk("word bit 2", 16'h0001, {15'h0, rsp_data[0]});
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        forever begin
            #12.5 clk = ~clk;
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        #1;
        reset_n = 1'b1;
        byte_mode();
        bit_ops();
        word_mode();
        results();
    end

    // all scenarios need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        results();
    end
endmodule
